// ===== verilog/fpd_param_decode.sv
`timescale 1ns/1ps
// Function
// - multi-track continues from last sector head 0 to first sector head 1
// - nonzero size code gives 128 shl code bytes, codes up to 7
// - size code zero uses 128 byte sector, short length sets count
// - short read drops excess bytes; short write pads zeros
// - no-dma flag set interrupts per byte, clear raises dma requests
// - perpendicular low bits change only when overwrite permit is set
// - poll disable stops the internal polling routine
// - precompensation applies from programmed start track 00 to ff
// - multi-sector transfers start at commanded sector, format at sector 1, then continue
// - relative seek moves by count from present cylinder
// - direction 0 steps out, 1 steps in toward spindle
// - format uses sectors per track; verify uses it when count enabled
// - count enable makes verify sectors per track byte the sector count
// - skip flag skips deleted-mark sectors on normal read
// - skip flag on read deleted accesses only deleted sectors
// - skip flag clear reads and writes every sector
// - step pulses spaced 0.5 to 8 ms in 0.5 ms steps at the 1 Mbit rate
// - status bytes 0 to 3 held and readable in result phase
// - write gate option shifts write enable for pre-erase
// - sense interrupt reports present cylinder
// - seek moves head to target cylinder
// - density select one is double density, zero single
module fpd_param_decode
    import fpd_pkg::*;
#(
    parameter int STEP_UNIT_CYC = FPD_STEP_UNIT_CYC,
    parameter int POLL_CYC = FPD_POLL_PERIOD_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // command parameters latched on CMD_START
    input wire logic CMD_START,
    input wire logic CMD_READ,
    input wire logic CMD_WRITE,
    input wire logic CMD_READ_DELETED,
    input wire logic CMD_FORMAT,
    input wire logic CMD_VERIFY,
    input wire logic CMD_SEEK,
    input wire logic CMD_REL_SEEK,
    input wire logic CMD_SENSE_INT,
    input wire logic MULTI_TRACK_FLAG,
    input wire logic DENSITY_SELECT,
    input wire logic SKIP_DELETED_FLAG,
    input wire logic NO_DMA_FLAG,
    input wire logic COUNT_ENABLE,
    input wire logic STEP_DIR,
    input wire logic [7:0] SECTOR_START,
    input wire logic [7:0] END_SECTOR,
    input wire logic [2:0] SIZE_CODE,
    input wire logic [7:0] SHORT_SECTOR_LENGTH,
    input wire logic [7:0] SECTORS_PER_TRACK,
    input wire logic [7:0] TARGET_CYLINDER,
    input wire logic [7:0] RELATIVE_CYLINDER_COUNT,
    // configuration
    input wire logic CFG_WRITE,
    input wire logic [7:0] PRECOMP_START_TRACK,
    input wire logic DRIVE_POLL_DISABLE,
    input wire logic [3:0] STEP_INTERVAL,
    input wire logic [1:0] DATA_RATE,
    input wire logic LOCK_WRITE,
    input wire logic OVERWRITE_PERMIT,
    input wire logic PERP_WRITE,
    input wire logic [3:0] PERP_LOW,
    input wire logic WRITE_GATE_TIMING,
    // drive-side byte stream
    input wire logic DISK_BYTE_VALID,
    input wire logic [7:0] DISK_BYTE,
    input wire logic DISK_DELETED_MARK,
    input wire logic HOST_ACK,
    input wire logic [7:0] HOST_WDATA,
    input wire logic [7:0] STATUS_IN_0,
    input wire logic [7:0] STATUS_IN_1,
    input wire logic [7:0] STATUS_IN_2,
    input wire logic [7:0] STATUS_IN_3,
    input wire logic RESULT_READ,
    // outputs to host side
    output logic HOST_BYTE_VALID,
    output logic [7:0] HOST_BYTE,
    output logic DMA_REQ,
    output logic DATA_INT,
    output logic [7:0] WRITE_BYTE,
    output logic WRITE_BYTE_VALID,
    output logic [7:0] RESULT_STATUS_0,
    output logic [7:0] RESULT_STATUS_1,
    output logic [7:0] RESULT_STATUS_2,
    output logic [7:0] RESULT_STATUS_3,
    output logic RESULT_READY,
    // drive-side controls
    output logic [7:0] CUR_SECTOR,
    output logic CUR_HEAD,
    output logic [7:0] PRESENT_CYLINDER,
    output logic STEP_PULSE,
    output logic STEP_IN,
    output logic PRECOMP_ON,
    output logic DOUBLE_DENSITY,
    output logic WRITE_ENABLE,
    output logic PRE_ERASE,
    output logic POLL_TICK,
    output logic [3:0] PERP_MODE,
    output logic BUSY
);
    fpd_state_t state;
    logic mt, sk, nd, is_wr, is_rdd, is_vfy, is_fmt;
    logic [7:0] last_sec;
    logic [14:0] sec_len;
    logic [14:0] xfer_len;
    logic [14:0] byte_idx;
    logic skip_sec;
    logic ow;
    logic [7:0] poll_cnt;
    logic [7:0] lead;
    logic [7:0] seek_steps;
    logic [7:0] next_cyl;
    logic sec_end;
    fpd_step_if st();

    fpd_stepper #(.UNIT_CYC(STEP_UNIT_CYC)) u_step (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .st(st)
    );

    // seek distance and destination cylinder
    always_comb begin
        if (CMD_REL_SEEK) begin
            seek_steps = RELATIVE_CYLINDER_COUNT;
            next_cyl = STEP_DIR ? PRESENT_CYLINDER + RELATIVE_CYLINDER_COUNT
                                : PRESENT_CYLINDER - RELATIVE_CYLINDER_COUNT;
        end else if (TARGET_CYLINDER >= PRESENT_CYLINDER) begin
            seek_steps = TARGET_CYLINDER - PRESENT_CYLINDER;
            next_cyl = TARGET_CYLINDER;
        end else begin
            seek_steps = PRESENT_CYLINDER - TARGET_CYLINDER;
            next_cyl = TARGET_CYLINDER;
        end
    end

    assign st.interval = STEP_INTERVAL;
    assign st.rate = DATA_RATE;
    assign st.steps = seek_steps;
    assign st.start = (state == FPD_IDLE) && CMD_START
                      && (CMD_SEEK || CMD_REL_SEEK);
    assign STEP_PULSE = st.pulse;
    assign sec_end = DISK_BYTE_VALID && byte_idx == sec_len - 15'h1;

    // command latch and phase sequencing
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state <= FPD_IDLE;
            mt <= 1'b0;
            sk <= 1'b0;
            nd <= 1'b0;
            is_wr <= 1'b0;
            is_rdd <= 1'b0;
            is_vfy <= 1'b0;
            is_fmt <= 1'b0;
            last_sec <= 8'h0;
            sec_len <= 15'h0;
            xfer_len <= 15'h0;
            DOUBLE_DENSITY <= 1'b0;
            STEP_IN <= 1'b0;
        end else begin
            case (state)
                FPD_IDLE: begin
                    if (CMD_START) begin
                        mt <= MULTI_TRACK_FLAG;
                        sk <= SKIP_DELETED_FLAG;
                        nd <= NO_DMA_FLAG;
                        is_wr <= CMD_WRITE || CMD_FORMAT;
                        is_rdd <= CMD_READ_DELETED;
                        is_vfy <= CMD_VERIFY;
                        is_fmt <= CMD_FORMAT;
                        DOUBLE_DENSITY <= DENSITY_SELECT;
                        sec_len <= fpd_sector_len(SIZE_CODE);
                        if (SIZE_CODE == 3'h0) begin
                            xfer_len <= {7'h0, SHORT_SECTOR_LENGTH};
                        end else begin
                            xfer_len <= fpd_sector_len(SIZE_CODE);
                        end
                        if (CMD_FORMAT || (CMD_VERIFY && COUNT_ENABLE)) begin
                            last_sec <= SECTORS_PER_TRACK;
                        end else begin
                            last_sec <= END_SECTOR;
                        end
                        if (CMD_SEEK || CMD_REL_SEEK) begin
                            STEP_IN <= CMD_REL_SEEK ? STEP_DIR
                                : (TARGET_CYLINDER > PRESENT_CYLINDER);
                            state <= FPD_SEEK;
                        end else if (CMD_SENSE_INT) begin
                            state <= FPD_DONE;
                        end else begin
                            state <= FPD_XFER;
                        end
                    end
                end
                FPD_SEEK: if (!st.busy && !st.start) state <= FPD_DONE;
                FPD_XFER: begin
                    if (sec_end && CUR_SECTOR == last_sec
                        && (!mt || CUR_HEAD)) begin
                        state <= FPD_DONE;
                    end
                end
                FPD_DONE: state <= FPD_RSLT;
                FPD_RSLT: if (RESULT_READ) state <= FPD_IDLE;
                default: state <= FPD_IDLE;
            endcase
        end
    end

    // sector and head walk
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            CUR_SECTOR <= 8'h0;
            CUR_HEAD <= 1'b0;
            byte_idx <= 15'h0;
        end else if (state == FPD_IDLE && CMD_START) begin
            CUR_SECTOR <= CMD_FORMAT ? 8'h1 : SECTOR_START;
            CUR_HEAD <= 1'b0;
            byte_idx <= 15'h0;
        end else if (state == FPD_XFER && DISK_BYTE_VALID) begin
            if (sec_end) begin
                byte_idx <= 15'h0;
                if (CUR_SECTOR == last_sec && mt && !CUR_HEAD) begin
                    CUR_SECTOR <= 8'h1;
                    CUR_HEAD <= 1'b1;
                end else begin
                    CUR_SECTOR <= CUR_SECTOR + 8'h1;
                end
            end else begin
                byte_idx <= byte_idx + 15'h1;
            end
        end
    end

    // deleted-mark filtering on reads
    always_comb begin
        skip_sec = 1'b0;
        if (sk && !is_wr && !is_fmt && !is_vfy) begin
            skip_sec = is_rdd ? !DISK_DELETED_MARK
                              : DISK_DELETED_MARK;
        end // sk clear: no sector skipped
    end

    // host-side data stream, truncated or zero-padded to short length
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            HOST_BYTE_VALID <= 1'b0;
            HOST_BYTE <= 8'h0;
            WRITE_BYTE <= 8'h0;
            WRITE_BYTE_VALID <= 1'b0;
        end else begin
            if (HOST_ACK) HOST_BYTE_VALID <= 1'b0;
            WRITE_BYTE_VALID <= 1'b0;
            if (state == FPD_XFER && DISK_BYTE_VALID) begin
                if (!is_wr && !is_vfy && !skip_sec
                    && byte_idx < xfer_len) begin
                    HOST_BYTE_VALID <= 1'b1;
                    HOST_BYTE <= DISK_BYTE;
                end
                if (is_wr) begin
                    WRITE_BYTE_VALID <= 1'b1;
                    WRITE_BYTE <= (byte_idx < xfer_len) ? HOST_WDATA
                                                        : 8'h00;
                end
            end
        end
    end

    // transfer request: dma or per-byte interrupt
    always_comb begin
        DMA_REQ = HOST_BYTE_VALID && !nd;
        DATA_INT = HOST_BYTE_VALID && nd;
    end

    // cylinder tracking and result status bytes
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PRESENT_CYLINDER <= 8'h0;
            RESULT_STATUS_0 <= 8'h0;
            RESULT_STATUS_1 <= 8'h0;
            RESULT_STATUS_2 <= 8'h0;
            RESULT_STATUS_3 <= 8'h0;
        end else begin
            if (state == FPD_IDLE && CMD_START
                && (CMD_SEEK || CMD_REL_SEEK)) begin
                PRESENT_CYLINDER <= next_cyl;
            end
            if (state == FPD_DONE) begin
                RESULT_STATUS_0 <= STATUS_IN_0;
                RESULT_STATUS_1 <= STATUS_IN_1;
                RESULT_STATUS_2 <= STATUS_IN_2;
                RESULT_STATUS_3 <= STATUS_IN_3;
            end
        end
    end
    assign RESULT_READY = (state == FPD_RSLT);
    assign BUSY = (state != FPD_IDLE);

    // configuration: precompensation, overwrite lock, perpendicular bits
    logic [7:0] precomp_trk;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            precomp_trk <= FPD_PRECOMP_RST;
            ow <= 1'b1;
            PERP_MODE <= FPD_PERP_RST;
        end else begin
            if (CFG_WRITE) precomp_trk <= PRECOMP_START_TRACK;
            if (LOCK_WRITE) ow <= OVERWRITE_PERMIT;
            if (PERP_WRITE && ow) PERP_MODE <= PERP_LOW;
        end
    end
    assign PRECOMP_ON = is_wr && (PRESENT_CYLINDER >= precomp_trk);

    // write enable with perpendicular pre-erase lead
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            lead <= 8'h0;
            WRITE_ENABLE <= 1'b0;
            PRE_ERASE <= 1'b0;
        end else if (state == FPD_XFER && is_wr) begin
            if (WRITE_GATE_TIMING && lead != 8'(FPD_WRITE_GATE_TIMING_LEAD_CYC)) begin
                lead <= lead + 8'h1;
                PRE_ERASE <= 1'b1;
                WRITE_ENABLE <= 1'b0;
            end else begin
                PRE_ERASE <= 1'b0;
                WRITE_ENABLE <= 1'b1;
            end
        end else begin
            lead <= 8'h0;
            WRITE_ENABLE <= 1'b0;
            PRE_ERASE <= 1'b0;
        end
    end

    // drive polling routine
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            poll_cnt <= 8'h0;
            POLL_TICK <= 1'b0;
        end else if (DRIVE_POLL_DISABLE || state != FPD_IDLE) begin
            poll_cnt <= 8'h0;
            POLL_TICK <= 1'b0;
        end else begin
            poll_cnt <= poll_cnt + 8'h1;
            POLL_TICK <= (poll_cnt == 8'(POLL_CYC - 1));
        end
    end
endmodule

// ===== verilog/fpd_pkg.sv
package fpd_pkg;
    localparam int FPD_BASE_SECTOR_BYTES = 128;
    localparam logic [2:0] FPD_MAX_SIZE_CODE = 3'h7;
    localparam logic [7:0] FPD_PRECOMP_RST = 8'h00;
    localparam logic [3:0] FPD_PERP_RST = 4'h0;
    localparam logic [3:0] FPD_STEP_RST = 4'h0;
    // half-millisecond step unit at the 1 Mbit rate
    localparam int FPD_STEP_UNIT_US = 500;
    localparam int FPD_CLK_MHZ = 250;
    localparam int FPD_STEP_UNIT_CYC = FPD_STEP_UNIT_US * FPD_CLK_MHZ;
    localparam int FPD_POLL_PERIOD_CYC = 256;
    localparam int FPD_WRITE_GATE_TIMING_LEAD_CYC = 8;
    // data rate codes: divisor of step unit relative to 1 Mbit
    localparam logic [1:0] FPD_RATE_1M = 2'h0;
    localparam logic [1:0] FPD_RATE_500K = 2'h1;
    localparam logic [1:0] FPD_RATE_250K = 2'h2;
    localparam logic [1:0] FPD_RATE_2M = 2'h3;

    typedef enum logic [4:0] {
        FPD_IDLE = 5'h01,
        FPD_XFER = 5'h02,
        FPD_SEEK = 5'h04,
        FPD_DONE = 5'h08,
        FPD_RSLT = 5'h10
    } fpd_state_t;

    // sector length in bytes for a size code
    function automatic logic [14:0] fpd_sector_len(input logic [2:0] code);
        fpd_sector_len = 15'(FPD_BASE_SECTOR_BYTES) << code;
    endfunction
endpackage

// ===== verilog/fpd_step_if.sv
`timescale 1ns/1ps
interface fpd_step_if;
    logic start;
    logic [3:0] interval;
    logic [1:0] rate;
    logic [7:0] steps;
    logic busy;
    logic pulse;
    modport ctl (output start, interval, rate, steps, input busy, pulse);
    modport gen (input start, interval, rate, steps, output busy, pulse);
endinterface

// ===== verilog/fpd_stepper.sv
`timescale 1ns/1ps
module fpd_stepper
    import fpd_pkg::*;
#(
    parameter int UNIT_CYC = FPD_STEP_UNIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    fpd_step_if.gen st
);
    logic [31:0] cnt;
    logic [31:0] span;
    logic [7:0] left;

    // interval code n means (n+1) half-ms, scaled inversely to data rate
    always_comb begin
        span = 32'(UNIT_CYC) * 32'({28'h0, st.interval} + 32'h1);
        case (st.rate)
            FPD_RATE_500K: span = span << 1;
            FPD_RATE_250K: span = span << 2;
            FPD_RATE_2M: span = span >> 1;
            default: span = span;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            left <= 8'h0;
            st.pulse <= 1'b0;
        end else begin
            st.pulse <= 1'b0;
            if (st.start && left == 8'h0) begin
                left <= st.steps;
                cnt <= 32'h0;
            end else if (left != 8'h0) begin
                if (cnt >= span - 32'h1) begin
                    cnt <= 32'h0;
                    left <= left - 8'h1;
                    st.pulse <= 1'b1;
                end else begin
                    cnt <= cnt + 32'h1;
                end
            end
        end
    end
    assign st.busy = (left != 8'h0);
endmodule

// ===== tb/fpd_param_decode_assertions.sv
`timescale 1ns/1ps
module fpd_param_decode_assertions
    import fpd_pkg::*;
#(
    parameter int STEP_UNIT_CYC = FPD_STEP_UNIT_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // command side
    input wire logic CMD_START,
    input wire logic CMD_READ,
    input wire logic CMD_SEEK,
    input wire logic CMD_REL_SEEK,
    input wire logic STEP_DIR,
    input wire logic [7:0] SECTOR_START,
    input wire logic [7:0] TARGET_CYLINDER,
    input wire logic [7:0] RELATIVE_CYLINDER_COUNT,
    input wire logic [3:0] STEP_INTERVAL,
    input wire logic [1:0] DATA_RATE,
    input wire logic PERP_WRITE,
    input wire logic DRIVE_POLL_DISABLE,
    input wire logic RESULT_READ,
    // observed outputs
    input wire logic HOST_BYTE_VALID,
    input wire logic DMA_REQ,
    input wire logic DATA_INT,
    input wire logic [7:0] RESULT_STATUS_0,
    input wire logic [7:0] RESULT_STATUS_3,
    input wire logic RESULT_READY,
    input wire logic [7:0] CUR_SECTOR,
    input wire logic [7:0] PRESENT_CYLINDER,
    input wire logic STEP_PULSE,
    input wire logic POLL_TICK,
    input wire logic [3:0] PERP_MODE,
    input wire logic BUSY
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [31:0] gap;
    logic [31:0] need;
    logic take;
    assign take = CMD_START && !BUSY;
    always_comb begin
        need = (32'(STEP_INTERVAL) + 32'h1) * 32'(STEP_UNIT_CYC);
        case (DATA_RATE)
            2'h1: need = need << 1;
            2'h2: need = need << 2;
            2'h3: need = need >> 1;
            default: need = need;
        endcase
    end
    // cycles since the previous step pulse, large at a new command
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || take) gap <= 32'hffff_0000;
        else if (STEP_PULSE) gap <= 32'h1;
        else gap <= gap + 32'h1;
    end
    chk_start_busy: assert property (take |=> BUSY)
        else $error("busy did not follow an accepted command");
    chk_first_sector: assert property (take && CMD_READ |=>
        CUR_SECTOR == $past(SECTOR_START))
        else $error("transfer did not start at the commanded sector");
    chk_seek_target: assert property (take && CMD_SEEK |=>
        PRESENT_CYLINDER == $past(TARGET_CYLINDER))
        else $error("seek did not reach the target cylinder");
    chk_rel_seek: assert property (take && CMD_REL_SEEK |=>
        PRESENT_CYLINDER == ($past(STEP_DIR) ?
        $past(PRESENT_CYLINDER) + $past(RELATIVE_CYLINDER_COUNT) :
        $past(PRESENT_CYLINDER) - $past(RELATIVE_CYLINDER_COUNT)))
        else $error("relative seek landed on the wrong cylinder");
    chk_step_gap: assert property (STEP_PULSE |-> gap >= need)
        else $error("step pulses closer than the programmed interval");
    chk_xfer_mode: assert property (HOST_BYTE_VALID |-> DMA_REQ ^ DATA_INT)
        else $error("byte pending without exactly one request kind");
    chk_req_idle: assert property (DMA_REQ || DATA_INT |-> HOST_BYTE_VALID)
        else $error("transfer request raised with no byte pending");
    chk_perp_lock: assert property ($changed(PERP_MODE) |-> $past(PERP_WRITE))
        else $error("perpendicular bits changed without a write");
    chk_poll_off: assert property (DRIVE_POLL_DISABLE &&
        $past(DRIVE_POLL_DISABLE) |-> !POLL_TICK)
        else $error("poll tick while polling is disabled");
    chk_result_hold: assert property (RESULT_READY && !RESULT_READ |=>
        RESULT_READY && $stable(RESULT_STATUS_0) && $stable(RESULT_STATUS_3))
        else $error("result status did not hold until read");
    cov_read: cover property (take && CMD_READ);
    cov_rel_in: cover property (take && CMD_REL_SEEK && STEP_DIR);
    cov_step: cover property (STEP_PULSE);
    cov_result: cover property (RESULT_READY && RESULT_READ);
endmodule
bind fpd_param_decode fpd_param_decode_assertions #(
    .STEP_UNIT_CYC(STEP_UNIT_CYC)
) i_fpd_param_decode_assertions (.*);

// ===== tb/fpd_host_model.sv
`timescale 1ns/1ps
module fpd_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // from the controller
    input wire logic byte_valid,
    input wire logic result_ready,
    input wire logic [1:0] delay,
    // to the controller
    output logic ack,
    output logic result_read
);
    logic [1:0] cnt;
    logic [1:0] rcnt;
    // takes each byte after a chosen wait, one pulse per byte
    always_ff @(posedge clk) begin
        if (!rst_n || ack) begin
            ack <= 1'h0;
            cnt <= 2'h0;
        end else if (byte_valid) begin
            if (cnt == delay) ack <= 1'h1;
            else cnt <= cnt + 2'h1;
        end
    end
    // reads the result phase after the same wait
    always_ff @(posedge clk) begin
        if (!rst_n || result_read) begin
            result_read <= 1'h0;
            rcnt <= 2'h0;
        end else if (result_ready) begin
            if (rcnt == delay) result_read <= 1'h1;
            else rcnt <= rcnt + 2'h1;
        end
    end
endmodule

// ===== tb/fpd_param_decode_test.sv
`timescale 1ns/1ps
module fpd_param_decode_test;
    import fpd_pkg::*;
    logic CORE_CLK = '0, RST_N = '0, CMD_START = '0, MULTI_TRACK_FLAG = '0;
    logic DENSITY_SELECT = '0, SKIP_DELETED_FLAG = '0, NO_DMA_FLAG = '0;
    logic COUNT_ENABLE = '0, STEP_DIR = '0, CFG_WRITE = '0, LOCK_WRITE = '0;
    logic DRIVE_POLL_DISABLE = '0, OVERWRITE_PERMIT = '0, PERP_WRITE = '0;
    logic WRITE_GATE_TIMING = '0, DISK_BYTE_VALID = '0, DISK_DELETED_MARK = '0;
    logic [7:0] SECTOR_START = '0, END_SECTOR = '0, SHORT_SECTOR_LENGTH = '0;
    logic [7:0] SECTORS_PER_TRACK = '0, TARGET_CYLINDER = '0, DISK_BYTE = '0;
    logic [7:0] RELATIVE_CYLINDER_COUNT = '0, PRECOMP_START_TRACK = '0;
    logic [7:0] HOST_WDATA = '0, STATUS_IN_0 = '0, STATUS_IN_1 = '0;
    logic [7:0] STATUS_IN_2 = '0, STATUS_IN_3 = '0, sel = '0;
    logic [3:0] STEP_INTERVAL = '0, PERP_LOW = '0;
    logic [2:0] SIZE_CODE = '0;
    logic [1:0] DATA_RATE = '0, dly = '0;
    logic CMD_READ, CMD_WRITE, CMD_READ_DELETED, CMD_FORMAT, CMD_VERIFY;
    logic CMD_SEEK, CMD_REL_SEEK, CMD_SENSE_INT, HOST_ACK, RESULT_READ;
    logic HOST_BYTE_VALID, DMA_REQ, DATA_INT, WRITE_BYTE_VALID, RESULT_READY;
    logic [7:0] HOST_BYTE, WRITE_BYTE, CUR_SECTOR, PRESENT_CYLINDER;
    logic [7:0] RESULT_STATUS_0, RESULT_STATUS_1, RESULT_STATUS_2;
    logic [7:0] RESULT_STATUS_3;
    logic CUR_HEAD, STEP_PULSE, STEP_IN, PRECOMP_ON, DOUBLE_DENSITY, BUSY;
    logic WRITE_ENABLE, PRE_ERASE, POLL_TICK;
    logic [3:0] PERP_MODE;
    int seed = 32'h5a3a, n_errors = 0, num_checks = 0, n_steps, n_poll, k;
    logic [9:0] q[$];
    logic [31:0] sq[$];
    logic [7:0] cyl = '0, tgt, relative_cylinder_count;
    logic dir;
    assign {CMD_SENSE_INT, CMD_REL_SEEK, CMD_SEEK, CMD_VERIFY, CMD_FORMAT,
        CMD_READ_DELETED, CMD_WRITE, CMD_READ} = sel;
    fpd_param_decode #(.STEP_UNIT_CYC(4)) i_fpd_param_decode (.*);
    fpd_host_model i_fpd_host_model (.clk(CORE_CLK), .rst_n(RST_N),
        .byte_valid(HOST_BYTE_VALID), .result_ready(RESULT_READY),
        .delay(dly), .ack(HOST_ACK), .result_read(RESULT_READ));
    always #2 CORE_CLK = ~CORE_CLK;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task issue(input logic [7:0] s);
        logic [31:0] st;
        @(posedge CORE_CLK);
        st = $random(seed);
        {STATUS_IN_0, STATUS_IN_1, STATUS_IN_2, STATUS_IN_3} <= st;
        sq.push_back(st);
        sel <= s;
        CMD_START <= 1'h1;
        @(posedge CORE_CLK);
        CMD_START <= 1'h0;
    endtask
    task wait_idle;
        int i;
        @(posedge CORE_CLK);
        for (i = 0; i < 20000 && BUSY !== 1'h0; i++) @(posedge CORE_CLK);
        chk(BUSY, 1'h0);
        chk(q.size(), 0);
    endtask
    task rd(input logic [7:0] s, input logic mt, sk, nd,
        input logic [2:0] code, input logic [7:0] len, st, en,
        input logic [3:0] del);
        int n, keep, i, j;
        logic [7:0] b;
        logic skip;
        n = en - st + 1 + (mt ? en : 0);
        keep = (code == 3'h0) ? len : (128 << code);
        {MULTI_TRACK_FLAG, SKIP_DELETED_FLAG, NO_DMA_FLAG} <= {mt, sk, nd};
        {SECTOR_START, END_SECTOR, SIZE_CODE} <= {st, en, code};
        SHORT_SECTOR_LENGTH <= len;
        {DENSITY_SELECT, COUNT_ENABLE, WRITE_GATE_TIMING,
            SECTORS_PER_TRACK} <= 11'($random(seed));
        dly <= 2'($random(seed));
        issue(s);
        for (i = 0; i < n; i++) begin
            skip = sk && (del[i] != s[2]);
            DISK_DELETED_MARK <= del[i];
            for (j = 0; j < (128 << code); j++) begin
                repeat (7) @(posedge CORE_CLK);
                if (j == 0 && i > en - st) chk({CUR_HEAD, CUR_SECTOR},
                    {1'h1, 8'(i - (en - st))});
                if (j == 0 && i <= en - st) chk(CUR_SECTOR, st + i);
                if (i + j == 0) chk(DOUBLE_DENSITY, DENSITY_SELECT);
                b = $random(seed);
                DISK_BYTE <= b;
                HOST_WDATA <= ~b;
                DISK_BYTE_VALID <= 1'h1;
                if (s[1]) q.push_back({2'h0, j < keep ? ~b : 8'h0});
                else if (!skip && j < keep) q.push_back({nd, ~nd, b});
                @(posedge CORE_CLK);
                DISK_BYTE_VALID <= 1'h0;
            end
        end
        wait_idle;
        $display("read test done for command %h", s);
    endtask
    task sk_run(input logic [7:0] s, input logic [7:0] e);
        n_steps = 0;
        issue(s);
        wait_idle;
        chk(PRESENT_CYLINDER, e);
        chk(n_steps, e > cyl ? e - cyl : cyl - e);
        if (s != 8'h80) chk(STEP_IN, s[6] ? dir : e > cyl);
        cyl = e;
    endtask
    task perp(input logic ow, input logic [3:0] v, input logic [3:0] e);
        OVERWRITE_PERMIT <= ow;
        LOCK_WRITE <= 1'h1;
        @(posedge CORE_CLK);
        LOCK_WRITE <= 1'h0;
        PERP_LOW <= v;
        PERP_WRITE <= 1'h1;
        @(posedge CORE_CLK);
        PERP_WRITE <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        chk(PERP_MODE, e);
    endtask
    always @(posedge CORE_CLK) begin
        if (STEP_PULSE === 1'h1) n_steps++;
        if (POLL_TICK === 1'h1) n_poll++;
        if (HOST_ACK && HOST_BYTE_VALID === 1'h1)
            chk({DATA_INT, DMA_REQ, HOST_BYTE}, q.size() ? q.pop_front() : 'x);
        if (WRITE_BYTE_VALID === 1'h1)
            chk(WRITE_BYTE, q.size() ? q.pop_front() : 'x);
        if (RESULT_READ && RESULT_READY === 1'h1)
            chk({RESULT_STATUS_0, RESULT_STATUS_1, RESULT_STATUS_2,
                RESULT_STATUS_3}, sq.size() ? sq.pop_front() : 'x);
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'h1;
        PRECOMP_START_TRACK <= 8'($random(seed));
        CFG_WRITE <= 1'h1;
        @(posedge CORE_CLK);
        CFG_WRITE <= 1'h0;
        // size codes kept to sectors any drive here can hold
        rd(8'h01, 0, 0, 0, 3'h0, 8'h05, 8'h03, 8'h03, 4'h0);
        rd(8'h02, 0, 0, 0, 3'h0, 8'h05, 8'h01, 8'h01, 4'h0);
        rd(8'h01, 0, 0, 1, 3'h2, 8'hff, 8'h01, 8'h01, 4'h0);
        rd(8'h01, 1, 0, 0, 3'h0, 8'h02, 8'h02, 8'h02, 4'h0);
        rd(8'h01, 0, 1, 1, 3'h0, 8'h03, 8'h01, 8'h02, 4'h1);
        rd(8'h04, 0, 1, 0, 3'h0, 8'h03, 8'h01, 8'h02, 4'h1);
        rd(8'h04, 0, 0, 0, 3'h0, 8'h04, 8'h01, 8'h02, 4'h3);
        for (k = 0; k < 4; k++) begin
            DATA_RATE <= 2'(k);
            STEP_INTERVAL <= 4'($random(seed) & 3);
            tgt = 8'($random(seed) & 15);
            TARGET_CYLINDER <= tgt;
            sk_run(8'h20, tgt);
            relative_cylinder_count = 8'($random(seed) & 15);
            dir = $random(seed);
            if (!dir && relative_cylinder_count > cyl) relative_cylinder_count = cyl;
            {STEP_DIR, RELATIVE_CYLINDER_COUNT} <= {dir, relative_cylinder_count};
            sk_run(8'h40, dir ? cyl + relative_cylinder_count : cyl - relative_cylinder_count);
            sk_run(8'h80, cyl);
        end
        $display("seek test done");
        perp(1, 4'ha, 4'ha);
        perp(0, 4'h5, 4'ha);
        perp(1, 4'h3, 4'h3);
        $display("perpendicular test done");
        DRIVE_POLL_DISABLE <= 1'h1;
        repeat (2) @(posedge CORE_CLK);
        n_poll = 0;
        repeat (600) @(posedge CORE_CLK);
        chk(n_poll, 0);
        DRIVE_POLL_DISABLE <= 1'h0;
        repeat (600) @(posedge CORE_CLK);
        chk(n_poll != 0, 1);
        $display("poll test done");
        wrap_up;
    end
endmodule
